//--- core/amc_pkg.sv
package amc_pkg;
   // Message type codes
   localparam logic [7:0] MT_AUTH_REQ = 8'h40;
   localparam logic [7:0] MT_AUTH_REPLY = 8'h41;
   // Element identifiers
   localparam logic [7:0] EI_CHALLENGE = 8'h0C;
   localparam logic [7:0] EI_RESPONSE = 8'h0D;
   localparam logic [7:0] EI_SEED = 8'h0E;
   localparam logic [7:0] EI_AUTH_TYPE = 8'h0A;
   // Element lengths in bytes (identifier and length octets included)
   localparam logic [7:0] LEN_CHALLENGE = 8'h0A;
   localparam logic [7:0] LEN_RESPONSE = 8'h06;
   localparam logic [7:0] LEN_SEED = 8'h0A;
   localparam logic [7:0] LEN_AUTH_TYPE = 8'h05;
   // Contents octets follow the identifier and length octets
   localparam logic [7:0] HDR_OCTETS = 8'h02;
   localparam logic [7:0] BODY_MAX = 8'h08;
   localparam int unsigned AT_BITS = 24;

   // Key-derivation inputs for one exchange
   typedef struct packed {
      logic [63:0] seed;
      logic [63:0] challenge;
      logic [31:0] response;
      logic [23:0] authType;
   } amc_keys_t;

   // One octet on the message stream
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } amc_octet_t;
endpackage

//--- core/auth_message_codec.sv
`timescale 1ns/10ps
`default_nettype none
module auth_message_codec
   import amc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic isFixed,
   input wire logic keyAlloc,
   input wire logic start,
   input wire amc_keys_t keys,
   input wire amc_octet_t rxIn,
   output amc_octet_t txOut,
   output logic [63:0] peerChallenge,
   output logic [31:0] peerResponse,
   output logic [23:0] peerAuthType,
   output logic authPass,
   output logic dropCall,
   output logic lengthError,
   output logic busy
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SEND = 4'b0010,
      S_WAIT = 4'b0100,
      S_DONE = 4'b1000
   } amc_state_t;

   // Expected element length for an identifier, zero when unknown
   function automatic logic [7:0] elemLen(input logic [7:0] id);
      unique case (id)
         EI_CHALLENGE: elemLen = LEN_CHALLENGE;
         EI_RESPONSE: elemLen = LEN_RESPONSE;
         EI_SEED: elemLen = LEN_SEED;
         EI_AUTH_TYPE: elemLen = LEN_AUTH_TYPE;
         default: elemLen = 8'h00;
      endcase
   endfunction

   amc_state_t state_q, state_d;
   logic [7:0] txBuf_q [0:39];
   logic [7:0] txBuf_d [0:39];
   logic [5:0] txIdx_q, txIdx_d, txCnt_q, txCnt_d;
   amc_octet_t txOut_d;
   logic replyMode_q, replyMode_d;
   // Receive parser
   logic [1:0] rxPos_q, rxPos_d; // 0 type, 1 id, 2 length, 3 body
   logic [7:0] rxId_q, rxId_d, rxLen_q, rxLen_d, rxCnt_q, rxCnt_d;
   logic [63:0] rxShift_q, rxShift_d;
   logic [7:0] rxType_q, rxType_d;
   logic [63:0] peerChallenge_d;
   logic [31:0] peerResponse_d;
   logic [23:0] peerAuthType_d;
   logic authPass_d, dropCall_d, lengthError_d, busy_d;
   logic msgEnd;

   // Next-state logic for builder, parser and sequencer
   always_comb begin
      logic [5:0] n;
      n = 6'd0;
      state_d = state_q;
      txBuf_d = txBuf_q;
      txIdx_d = txIdx_q;
      txCnt_d = txCnt_q;
      replyMode_d = replyMode_q;
      txOut_d = '0;
      rxPos_d = rxPos_q;
      rxId_d = rxId_q;
      rxLen_d = rxLen_q;
      rxCnt_d = rxCnt_q;
      rxShift_d = rxShift_q;
      rxType_d = rxType_q;
      peerChallenge_d = peerChallenge;
      peerResponse_d = peerResponse;
      peerAuthType_d = peerAuthType;
      authPass_d = 1'b0;
      dropCall_d = 1'b0;
      lengthError_d = 1'b0;
      msgEnd = 1'b0;

      // Parse: type octet, then identifier/length/contents elements
      if (rxIn.valid) begin
         unique case (rxPos_q)
            2'd0: begin
               rxType_d = rxIn.data;
               rxPos_d = 2'd1;
            end
            2'd1: begin
               rxId_d = rxIn.data;
               rxPos_d = 2'd2;
            end
            2'd2: begin
               rxLen_d = rxIn.data;
               rxCnt_d = HDR_OCTETS;
               rxShift_d = '0;
               // Mismatched length on a known element is rejected
               if (elemLen(rxId_q) != 8'h00
                   && rxIn.data != elemLen(rxId_q)) begin
                  lengthError_d = 1'b1;
               end
               rxPos_d = (rxIn.data > HDR_OCTETS) ? 2'd3 : 2'd1;
            end
            default: begin
               rxShift_d = {rxShift_q[55:0], rxIn.data};
               rxCnt_d = rxCnt_q + 8'h01;
               if (rxCnt_q + 8'h01 >= rxLen_q) begin
                  rxPos_d = 2'd1;
                  // Unknown or mis-sized elements simply fall away
                  if (rxLen_q == elemLen(rxId_q)) begin
                     unique case (rxId_q)
                        EI_CHALLENGE: peerChallenge_d = rxShift_d;
                        EI_RESPONSE: peerResponse_d = rxShift_d[31:0];
                        EI_AUTH_TYPE: peerAuthType_d = rxShift_d[23:0];
                        default: ;
                     endcase
                  end
               end
            end
         endcase
         if (rxIn.last) begin
            rxPos_d = 2'd0;
            msgEnd = 1'b1;
         end
      end

      // Builder helpers write whole elements, MSB first
      unique case (state_q)
         S_IDLE: begin
            if (start) begin
               n = 6'd0;
               txBuf_d[n] = MT_AUTH_REQ;
               n = n + 6'd1;
               txBuf_d[n] = EI_AUTH_TYPE;
               txBuf_d[n + 6'd1] = LEN_AUTH_TYPE;
               for (int i = 0; i < 3; i++)
                  txBuf_d[n + 6'd2 + 6'(i)] = keys.authType[23 - 8*i -: 8];
               n = n + 6'(LEN_AUTH_TYPE);
               if (isFixed) begin
                  txBuf_d[n] = EI_SEED;
                  txBuf_d[n + 6'd1] = LEN_SEED;
                  for (int i = 0; i < 8; i++)
                     txBuf_d[n + 6'd2 + 6'(i)] = keys.seed[63 - 8*i -: 8];
                  n = n + 6'(LEN_SEED);
               end
               txBuf_d[n] = EI_CHALLENGE;
               txBuf_d[n + 6'd1] = LEN_CHALLENGE;
               for (int i = 0; i < 8; i++)
                  txBuf_d[n + 6'd2 + 6'(i)] = keys.challenge[63 - 8*i -: 8];
               n = n + 6'(LEN_CHALLENGE);
               if (!isFixed && keyAlloc) begin
                  txBuf_d[n] = EI_RESPONSE;
                  txBuf_d[n + 6'd1] = LEN_RESPONSE;
                  for (int i = 0; i < 4; i++)
                     txBuf_d[n + 6'd2 + 6'(i)] = keys.response[31 - 8*i -: 8];
                  n = n + 6'(LEN_RESPONSE);
               end
               txCnt_d = n;
               txIdx_d = 6'd0;
               replyMode_d = 1'b0;
               state_d = S_SEND;
            end else if (msgEnd && rxType_d == MT_AUTH_REQ) begin
               // Peer asked; answer with our response (and seed if fixed)
               n = 6'd0;
               txBuf_d[n] = MT_AUTH_REPLY;
               n = n + 6'd1;
               if (isFixed) begin
                  txBuf_d[n] = EI_SEED;
                  txBuf_d[n + 6'd1] = LEN_SEED;
                  for (int i = 0; i < 8; i++)
                     txBuf_d[n + 6'd2 + 6'(i)] = keys.seed[63 - 8*i -: 8];
                  n = n + 6'(LEN_SEED);
               end
               txBuf_d[n] = EI_RESPONSE;
               txBuf_d[n + 6'd1] = LEN_RESPONSE;
               for (int i = 0; i < 4; i++)
                  txBuf_d[n + 6'd2 + 6'(i)] = keys.response[31 - 8*i -: 8];
               n = n + 6'(LEN_RESPONSE);
               txCnt_d = n;
               txIdx_d = 6'd0;
               replyMode_d = 1'b1;
               state_d = S_SEND;
            end
         end
         S_SEND: begin
            txOut_d.valid = 1'b1;
            txOut_d.data = txBuf_q[txIdx_q];
            txOut_d.last = (txIdx_q + 6'd1 == txCnt_q);
            txIdx_d = txIdx_q + 6'd1;
            if (txIdx_q + 6'd1 == txCnt_q)
               state_d = replyMode_q ? S_IDLE : S_WAIT;
         end
         S_WAIT: begin
            // Compare returned response with the expected one
            if (msgEnd && rxType_d == MT_AUTH_REPLY) begin
               if (peerResponse_d == keys.response)
                  authPass_d = 1'b1;
               else
                  dropCall_d = 1'b1;
               state_d = S_DONE;
            end
         end
         default: state_d = S_IDLE;
      endcase
      busy_d = (state_d != S_IDLE);
   end

   // Register stage
   always_ff @(posedge clk) begin
      txBuf_q <= txBuf_d;
      rxShift_q <= rxShift_d;
      if (reset) begin
         state_q <= S_IDLE;
         txIdx_q <= '0;
         txCnt_q <= '0;
         replyMode_q <= 1'b0;
         txOut <= '0;
         rxPos_q <= '0;
         rxId_q <= '0;
         rxLen_q <= '0;
         rxCnt_q <= '0;
         rxType_q <= '0;
         peerChallenge <= '0;
         peerResponse <= '0;
         peerAuthType <= '0;
         authPass <= 1'b0;
         dropCall <= 1'b0;
         lengthError <= 1'b0;
         busy <= 1'b0;
      end else begin
         state_q <= state_d;
         txIdx_q <= txIdx_d;
         txCnt_q <= txCnt_d;
         replyMode_q <= replyMode_d;
         txOut <= txOut_d;
         rxPos_q <= rxPos_d;
         rxId_q <= rxId_d;
         rxLen_q <= rxLen_d;
         rxCnt_q <= rxCnt_d;
         rxType_q <= rxType_d;
         peerChallenge <= peerChallenge_d;
         peerResponse <= peerResponse_d;
         peerAuthType <= peerAuthType_d;
         authPass <= authPass_d;
         dropCall <= dropCall_d;
         lengthError <= lengthError_d;
         busy <= busy_d;
      end
   end

   // Checks on the outgoing stream, received length rejection and verdicts
   a_type_top_zero: assert property (@(posedge clk) disable iff (reset)
      (txOut.valid && $past(state_q) == S_SEND && $past(txIdx_q) == 6'd0)
      |-> !txOut.data[7]) else $error("type octet top bit set");
   a_type_code: assert property (@(posedge clk) disable iff (reset)
      (state_q == S_IDLE && start) ##1 1'b1 |=>
      txOut.valid && txOut.data == MT_AUTH_REQ)
      else $error("request type code wrong");
   a_first_elem: assert property (@(posedge clk) disable iff (reset)
      (state_q == S_IDLE && start) |-> ##3 txOut.data == EI_AUTH_TYPE
      ##1 txOut.data == LEN_AUTH_TYPE)
      else $error("auth type element not first");
   a_seed_fixed: assert property (@(posedge clk) disable iff (reset)
      (state_q == S_IDLE && start && isFixed) |-> ##8 txOut.data == EI_SEED
      ##1 txOut.data == LEN_SEED) else $error("seed missing");
   a_chal_msb: assert property (@(posedge clk) disable iff (reset)
      (state_q == S_IDLE && start && !isFixed) |-> ##8
      txOut.data == EI_CHALLENGE ##2 txOut.data == $past(keys.challenge[63:56], 10))
      else $error("challenge msb octet misplaced");
   a_pass_drop_excl: assert property (@(posedge clk) disable iff (reset)
      !(authPass && dropCall)) else $error("pass and drop together");
   a_drop_cause: assert property (@(posedge clk) disable iff (reset)
      dropCall |-> $past(state_q) == S_WAIT
      && $past(peerResponse_d) != $past(keys.response))
      else $error("drop without mismatch");
   a_len_reject: assert property (@(posedge clk) disable iff (reset)
      (rxIn.valid && rxPos_q == 2'd2 && rxId_q == EI_RESPONSE
      && rxIn.data != LEN_RESPONSE) |=> lengthError)
      else $error("bad length accepted");
endmodule
`default_nettype wire

//--- dv/amc_peer.sv
`timescale 1ns/10ps
`default_nettype none
module amc_peer
   import amc_pkg::*;
(
   input wire logic clk,
   input wire amc_octet_t txOut,
   input wire logic peerFixed,
   input wire logic [63:0] seedVal,
   input wire logic [31:0] respVal,
   input wire logic extra,
   input wire logic badLen,
   input wire logic [7:0] gap,
   input wire logic reqGo,
   output amc_octet_t rxIn
);
   logic [7:0] msg[$];
   // Asks on reqGo, answers each complete codec message (request or reply) with a reply after a gap
   initial begin
      rxIn = '0;
      forever begin
         @(negedge clk);
         msg = {};
         if (reqGo === 1'b1) begin
            // Request: auth type then challenge, MSB octet first
            msg = {MT_AUTH_REQ, EI_AUTH_TYPE, LEN_AUTH_TYPE, respVal[23:16],
               respVal[15:8], respVal[7:0], EI_CHALLENGE, LEN_CHALLENGE};
            for (int i = 7; i >= 0; i--) msg.push_back(seedVal[8*i+:8]);
         end else if (txOut.valid === 1'b1 && txOut.last === 1'b1) begin
            msg = {MT_AUTH_REPLY};
            if (extra) msg = {msg, 8'h7B, 8'h03, 8'h5A};
            if (peerFixed) begin
               msg = {msg, EI_SEED, LEN_SEED};
               for (int i = 7; i >= 0; i--) msg.push_back(seedVal[8*i+:8]);
            end
            // Response element, wrong length only when commanded
            msg = {msg, EI_RESPONSE, badLen ? 8'h07 : LEN_RESPONSE};
            for (int i = 3; i >= 0; i--) msg.push_back(respVal[8*i+:8]);
         end
         if (msg.size() != 0) begin
            repeat (gap) @(posedge clk);
            foreach (msg[i]) begin
               @(posedge clk);
               rxIn <= '{1'b1, i == msg.size() - 1, msg[i]};
            end
            @(posedge clk);
            rxIn <= '{1'b0, 1'b0, ~rxIn.data}; // Released line shows inverse
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/auth_message_codec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module auth_message_codec_tb_top
   import amc_pkg::*;
;
   logic clk, reset, isFixed, keyAlloc, start, authPass, dropCall;
   logic lengthError, busy, peerFixed, extra, badLen, reqGo;
   logic [63:0] peerChallenge;
   logic [23:0] peerAuthType;
   logic [31:0] respVal, peerResponse;
   logic [7:0] gap;
   logic [7:0] exp[$];
   amc_keys_t keys;
   amc_octet_t rxIn, txOut;
   int mismatches, checks, nPass, nDrop, nLen;
   auth_message_codec dut (.clk(clk), .reset(reset), .isFixed(isFixed),
      .keyAlloc(keyAlloc), .start(start), .keys(keys), .rxIn(rxIn),
      .txOut(txOut), .peerChallenge(peerChallenge),
      .peerResponse(peerResponse),
      .peerAuthType(peerAuthType), .authPass(authPass), .dropCall(dropCall),
      .lengthError(lengthError), .busy(busy));
   amc_peer peer (.clk(clk), .txOut(txOut), .peerFixed(peerFixed),
      .seedVal(keys.seed), .respVal(respVal), .extra(extra),
      .badLen(badLen), .gap(gap), .reqGo(reqGo), .rxIn(rxIn));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse counters
   always @(negedge clk) begin
      nPass += (authPass === 1'b1);
      nDrop += (dropCall === 1'b1);
      nLen += (lengthError === 1'b1);
   end
   task automatic check(input string name, input logic [63:0] e,
      input logic [63:0] s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Expected element: identifier, length, value MSB octet first
   task automatic add(input logic [7:0] id, ln, input logic [63:0] v,
      input int n);
      exp.push_back(id);
      exp.push_back(ln);
      for (int i = n - 1; i >= 0; i--) exp.push_back(v[8*i+:8]);
   endtask
   // Reset, send our request, check it, wait for the verdict
   task automatic exchange(input logic fx, ka, bl, ex,
      input logic [31:0] r, input logic [7:0] g);
      logic [7:0] got[$];
      int n;
      reset <= 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      isFixed <= fx;
      keyAlloc <= ka;
      badLen <= bl;
      extra <= ex;
      respVal <= r;
      peerFixed <= ~fx;
      gap <= g;
      nPass = 0;
      nDrop = 0;
      nLen = 0;
      exp = {MT_AUTH_REQ};
      add(EI_AUTH_TYPE, LEN_AUTH_TYPE, keys.authType, 3);
      if (fx) add(EI_SEED, LEN_SEED, keys.seed, 8);
      add(EI_CHALLENGE, LEN_CHALLENGE, keys.challenge, 8);
      if (ka && !fx) add(EI_RESPONSE, LEN_RESPONSE, keys.response, 4);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (n < 40 && !(txOut.valid === 1'b1 && txOut.last === 1'b1)) begin
         @(negedge clk);
         if (txOut.valid === 1'b1) got.push_back(txOut.data);
         n++;
      end
      check("request size", exp.size(), got.size());
      foreach (exp[i]) check("request octet", exp[i], got[i]);
      n = 0;
      while (n < 300 && nPass + nDrop + nLen == 0) begin
         @(negedge clk);
         n++;
      end
      repeat (5) @(negedge clk);
   endtask
   task automatic t_portable_pass;
      exchange(1'b0, 1'b0, 1'b0, 1'b1, keys.response, 8'h00);
      check("pass", 1, nPass);
      check("drop", 0, nDrop);
      check("peer response", keys.response, peerResponse);
   endtask
   task automatic t_fixed_mismatch;
      exchange(1'b1, 1'b0, 1'b0, 1'b0, keys.response ^ 32'h1, 8'h03);
      check("drop", 1, nDrop);
      check("pass", 0, nPass);
   endtask
   task automatic t_fixed_pass;
      exchange(1'b1, 1'b0, 1'b0, 1'b0, keys.response, 8'h00);
      check("pass", 1, nPass);
      check("drop", 0, nDrop);
   endtask
   task automatic t_keyalloc_drop;
      exchange(1'b0, 1'b1, 1'b0, 1'b0, keys.response ^ 32'h80000000, 8'h01);
      check("drop", 1, nDrop);
   endtask
   task automatic t_bad_length;
      exchange(1'b0, 1'b0, 1'b1, 1'b0, keys.response, 8'h00);
      check("length error", 1, nLen);
      check("pass", 0, nPass);
      check("not stored", 32'h0, peerResponse);
   endtask
   // Peer asks, we reply; stored challenge and auth type checked
   task automatic t_answer_request(input logic fx);
      logic [7:0] got[$];
      int n;
      reset <= 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      isFixed <= fx;
      peerFixed <= ~fx;
      respVal <= 32'h00C3A51E;
      gap <= 8'h02;
      exp = {MT_AUTH_REPLY};
      if (fx) add(EI_SEED, LEN_SEED, keys.seed, 8);
      add(EI_RESPONSE, LEN_RESPONSE, keys.response, 4);
      @(posedge clk);
      reqGo <= 1'b1;
      @(posedge clk);
      reqGo <= 1'b0;
      n = 0;
      while (n < 80 && !(txOut.valid === 1'b1 && txOut.last === 1'b1)) begin
         @(negedge clk);
         if (txOut.valid === 1'b1) got.push_back(txOut.data);
         n++;
      end
      check("reply size", exp.size(), got.size());
      foreach (exp[i]) check("reply octet", exp[i], got[i]);
      check("busy after reply", 0, busy);
      check("peer challenge", keys.seed, peerChallenge);
      check("peer auth type", 24'hC3A51E, peerAuthType);
      repeat (40) @(negedge clk);
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   // Main sequence
   initial begin
      {reset, isFixed, keyAlloc, start, peerFixed, extra, badLen} = 7'h40;
      respVal = 32'h0;
      reqGo = 1'b0;
      gap = 8'h00;
      keys = '{64'h0123456789ABCDEF, 64'h8000000000000001, 32'hA5C30F81,
         24'h010283};
      t_portable_pass();
      t_fixed_mismatch();
      t_fixed_pass();
      t_keyalloc_drop();
      t_bad_length();
      t_answer_request(1'b1);
      t_answer_request(1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
